// file: pkg/adc_dma_pkg.sv
package adc_dma_pkg;
  // Register byte offsets
  localparam logic [7:0] TIMING_OFS   = 8'h00;
  localparam logic [7:0] CHANNEL_OFS  = 8'h04;
  localparam logic [7:0] PTR_LOW_OFS  = 8'h08;
  localparam logic [7:0] PTR_HIGH_OFS = 8'h0C;
  localparam logic [7:0] PTR_PAGE_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS   = 8'h14;
  localparam logic [7:0] RESULT_OFS   = 8'h18;

  // Timing/configuration field positions
  localparam int TC_PWR_LO   = 8;
  localparam int TC_PWR_HI   = 7;
  localparam int TC_EXT_REF  = 6;
  localparam int TC_DIV      = 4;
  localparam int TC_ACQ      = 2;
  localparam int TC_T2_TRIG  = 1;
  localparam int TC_EXT_TRIG = 0;

  // Channel control field positions
  localparam int CC_DMA    = 6;
  localparam int CC_CONT   = 5;
  localparam int CC_SINGLE = 4;
  localparam int CC_CH     = 0;

  // Status field positions
  localparam int ST_DONE = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_DMA  = 2;

  // Values after reset
  localparam logic [8:0]  TIMING_RST  = 9'h000;
  localparam logic [7:0]  CHANNEL_RST = 8'h00;
  localparam logic [7:0]  PTR_RST     = 8'h00;
  localparam logic [11:0] RESULT_RST  = 12'h000;

  // Divider select codes and terminal counts
  localparam logic [1:0] DIV_BY_32 = 2'b00;
  localparam logic [1:0] DIV_BY_4  = 2'b01;
  localparam logic [1:0] DIV_BY_8  = 2'b10;
  localparam logic [1:0] DIV_BY_2  = 2'b11;
  localparam logic [4:0] DIV32_LAST = 5'h1F;
  localparam logic [4:0] DIV4_LAST  = 5'h03;
  localparam logic [4:0] DIV8_LAST  = 5'h07;
  localparam logic [4:0] DIV2_LAST  = 5'h01;

  // Conversion timing in conversion clocks
  localparam logic [4:0] SYNC_CLKS = 5'h01;
  localparam logic [4:0] CONV_CLKS = 5'h0F;

  // DMA list encoding
  localparam logic [3:0]  STOP_ID   = 4'hF;
  localparam logic [23:0] SLOT_STEP = 24'h000002;
  localparam logic [7:0]  GATED_RD  = 8'hFF;
endpackage

// file: pkg/conv_if.sv
`timescale 1ns/1ps
`default_nettype none
interface conv_if;
  logic [1:0] div_sel;
  logic [1:0] acq_sel;
  logic       tick;
  logic       start;
  logic       busy;
  logic       done;
  logic       sampling;
  modport ctl (output div_sel, acq_sel, start,
               input tick, busy, done, sampling);
  modport div (input div_sel, output tick);
  modport cnv (input tick, acq_sel, start,
               output busy, done, sampling);
endinterface
`default_nettype wire

// file: hw/conv_clk_divider.sv
`timescale 1ns/1ps
`default_nettype none
module conv_clk_divider (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Converter timing
  conv_if.div       cv
);
  logic [4:0] cnt_reg;
  logic       tick_reg;

  function automatic logic [4:0] div_last(input logic [1:0] sel);
    case (sel)
      adc_dma_pkg::DIV_BY_4: div_last = adc_dma_pkg::DIV4_LAST;
      adc_dma_pkg::DIV_BY_8: div_last = adc_dma_pkg::DIV8_LAST;
      adc_dma_pkg::DIV_BY_2: div_last = adc_dma_pkg::DIV2_LAST;
      default:               div_last = adc_dma_pkg::DIV32_LAST;
    endcase
  endfunction

  // One tick per conversion clock period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg  <= 5'h00;
      tick_reg <= 1'b0;
    end else if (cnt_reg >= div_last(cv.div_sel)) begin
      cnt_reg  <= 5'h00;
      tick_reg <= 1'b1;
    end else begin
      cnt_reg  <= cnt_reg + 5'h01;
      tick_reg <= 1'b0;
    end
  end

  assign cv.tick = tick_reg;
endmodule
`default_nettype wire

// file: hw/conv_timer.sv
`timescale 1ns/1ps
`default_nettype none
module conv_timer (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Converter timing
  conv_if.cnv       cv
);
  logic [4:0] cnt_reg;
  logic       busy_reg;
  logic       done_reg;
  logic [4:0] acq_clks;
  logic [4:0] last_cnt;

  assign acq_clks = {3'b000, cv.acq_sel} + 5'h01;
  assign last_cnt = adc_dma_pkg::SYNC_CLKS + acq_clks
                    + adc_dma_pkg::CONV_CLKS - 5'h01;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg  <= 5'h00;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (cv.start && !busy_reg) begin
        cnt_reg  <= 5'h00;
        busy_reg <= 1'b1;
      end else if (busy_reg && cv.tick) begin
        if (cnt_reg == last_cnt) begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 5'h01;
        end
      end
    end
  end

  // Track phase follows the synchronisation clock
  assign cv.sampling = busy_reg && (cnt_reg >= adc_dma_pkg::SYNC_CLKS)
                       && (cnt_reg < adc_dma_pkg::SYNC_CLKS + acq_clks);
  assign cv.busy = busy_reg;
  assign cv.done = done_reg;
endmodule
`default_nettype wire

// file: hw/adc_dma_capture.sv
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module adc_dma_capture (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Conversion triggers
  input  wire logic        timer2_overflow,
  input  wire logic        ext_trigger,
  // Analog front end
  input  wire logic [11:0] adc_result,
  output logic      [3:0]  adc_channel,
  output logic             adc_sampling,
  output logic             adc_power,
  output logic             reference_external,
  output logic             reference_internal_on,
  output logic             conversion_done_flag,
  // Core external memory requests
  input  wire logic [23:0] core_addr,
  input  wire logic [7:0]  core_wdata,
  input  wire logic        core_we,
  input  wire logic        core_re,
  output logic      [7:0]  core_rdata,
  // External SRAM
  output logic      [23:0] mem_addr,
  output logic      [7:0]  mem_wdata,
  input  wire logic [7:0]  mem_rdata,
  output logic             mem_data_oe_n,
  output logic             mem_we_n,
  output logic             mem_oe_n
);
  typedef enum logic [2:0] {
    D_IDLE = 3'b001,
    D_RUN  = 3'b010,
    D_LAST = 3'b100
  } dma_state_e;

  typedef enum logic [4:0] {
    M_IDLE    = 5'b00001,
    M_WR_HI   = 5'b00010,
    M_WR_LO   = 5'b00100,
    M_RD      = 5'b01000,
    M_RD_WAIT = 5'b10000
  } mem_state_e;

  conv_if cv ();

  conv_clk_divider u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .cv      (cv.div)
  );

  conv_timer u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .cv      (cv.cnv)
  );

  logic [8:0]  timing_reg;
  logic [7:0]  chan_reg;
  logic [7:0]  ptr_low_reg;
  logic [7:0]  ptr_high_reg;
  logic [7:0]  ptr_page_reg;
  logic [11:0] result_reg;
  logic [3:0]  result_ch_reg;
  logic        done_reg;
  logic        sw_start_reg;
  logic        finish_reg;
  logic        conv_start_reg;
  logic [3:0]  ch_reg;
  dma_state_e  dma_state;
  mem_state_e  mem_state;
  logic [23:0] ptr_reg;
  logic [23:0] cur_slot;
  logic [23:0] next_slot;
  logic [23:0] pend_slot;
  logic [3:0]  cur_id;
  logic [3:0]  next_id;
  logic [3:0]  pend_id;
  logic [11:0] pend_res;
  logic        pend_valid;
  logic        next_valid;
  logic        stop_seen;
  logic        do_read;
  logic        free_run;
  logic [2:0]  ext_sync;
  logic [7:0]  rd_s1;
  logic [7:0]  rd_s2;
  logic        wr_en;
  logic        rd_setup;
  logic        powered;
  logic        dma_mode;
  logic        trig_any;
  logic        go;
  logic        done_set;
  logic        done_clr;

  assign powered  = timing_reg[adc_dma_pkg::TC_PWR_HI];
  assign dma_mode = chan_reg[adc_dma_pkg::CC_DMA];
  assign wr_en    = psel && penable && pwrite;
  assign rd_setup = psel && !penable;

  // Synchronisers; first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_sync <= 3'b000;
      rd_s1    <= 8'h00;
      rd_s2    <= 8'h00;
    end else begin
      ext_sync <= {ext_sync[1:0], ext_trigger};
      rd_s1    <= mem_rdata;
      rd_s2    <= rd_s1;
    end
  end

  assign trig_any = sw_start_reg
    || (timing_reg[adc_dma_pkg::TC_T2_TRIG] && timer2_overflow)
    || (timing_reg[adc_dma_pkg::TC_EXT_TRIG]
        && ext_sync[1] && !ext_sync[2]);

  // Software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timing_reg   <= adc_dma_pkg::TIMING_RST;
      chan_reg     <= adc_dma_pkg::CHANNEL_RST;
      ptr_low_reg  <= adc_dma_pkg::PTR_RST;
      ptr_high_reg <= adc_dma_pkg::PTR_RST;
      ptr_page_reg <= adc_dma_pkg::PTR_RST;
      sw_start_reg <= 1'b0;
    end else begin
      sw_start_reg <= 1'b0;
      if (wr_en) begin
        case (paddr)
          adc_dma_pkg::TIMING_OFS:   timing_reg   <= pwdata[8:0];
          adc_dma_pkg::PTR_LOW_OFS:  ptr_low_reg  <= pwdata[7:0];
          adc_dma_pkg::PTR_HIGH_OFS: ptr_high_reg <= pwdata[7:0];
          adc_dma_pkg::PTR_PAGE_OFS: ptr_page_reg <= pwdata[7:0];
          adc_dma_pkg::CHANNEL_OFS: begin
            chan_reg <= pwdata[7:0] & ~(8'h01 << adc_dma_pkg::CC_SINGLE);
            sw_start_reg <= pwdata[adc_dma_pkg::CC_SINGLE];
          end
          default: ;
        endcase
      end
    end
  end

  // Sticky done flag; a set in the clearing cycle wins
  assign done_set = (cv.done && dma_state == D_IDLE) || finish_reg;
  assign done_clr = wr_en && paddr == adc_dma_pkg::STATUS_OFS
                    && pwdata[adc_dma_pkg::ST_DONE];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_reg <= 1'b0;
    end else if (done_set) begin
      done_reg <= 1'b1;
    end else if (done_clr) begin
      done_reg <= 1'b0;
    end
  end

  // Read data is latched in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (rd_setup) begin
      pslverr <= 1'b0;
      case (paddr)
        adc_dma_pkg::TIMING_OFS:   prdata <= {23'h000000, timing_reg};
        adc_dma_pkg::CHANNEL_OFS:  prdata <= {24'h000000, chan_reg};
        adc_dma_pkg::PTR_LOW_OFS:  prdata <= {24'h000000, ptr_low_reg};
        adc_dma_pkg::PTR_HIGH_OFS: prdata <= {24'h000000, ptr_high_reg};
        adc_dma_pkg::PTR_PAGE_OFS: prdata <= {24'h000000, ptr_page_reg};
        adc_dma_pkg::STATUS_OFS:
          prdata <= {29'h00000000, dma_state != D_IDLE, cv.busy, done_reg};
        adc_dma_pkg::RESULT_OFS:
          prdata <= {16'h0000, result_ch_reg, result_reg};
        default: begin
          prdata  <= 32'h0000_0000;
          pslverr <= 1'b1;
        end
      endcase
    end
  end

  assign pready = 1'b1;

  // A DMA step may start only between conversions
  assign go = dma_state != D_IDLE && mem_state == M_IDLE && !cv.busy
              && !conv_start_reg && !cv.done && (free_run || trig_any);

  // Conversion requests and DMA pipeline
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_start_reg <= 1'b0;
      finish_reg     <= 1'b0;
      ch_reg         <= 4'h0;
      result_reg     <= adc_dma_pkg::RESULT_RST;
      result_ch_reg  <= 4'h0;
      dma_state      <= D_IDLE;
      mem_state      <= M_IDLE;
      ptr_reg        <= 24'h000000;
      cur_slot       <= 24'h000000;
      next_slot      <= 24'h000000;
      pend_slot      <= 24'h000000;
      cur_id         <= 4'h0;
      next_id        <= 4'h0;
      pend_id        <= 4'h0;
      pend_res       <= 12'h000;
      pend_valid     <= 1'b0;
      next_valid     <= 1'b0;
      stop_seen      <= 1'b0;
      do_read        <= 1'b0;
      free_run       <= 1'b0;
    end else begin
      conv_start_reg <= 1'b0;
      finish_reg     <= 1'b0;
      case (dma_state)
        D_IDLE: begin
          if (cv.done) begin
            result_reg    <= adc_result;
            result_ch_reg <= ch_reg;
          end
          if (dma_mode && powered && trig_any && !cv.busy) begin
            dma_state  <= D_RUN;
            ptr_reg    <= {ptr_page_reg, ptr_high_reg, ptr_low_reg};
            free_run   <= sw_start_reg;
            pend_valid <= 1'b0;
            next_valid <= 1'b0;
            stop_seen  <= 1'b0;
            do_read    <= 1'b1;
            mem_state  <= M_RD;
          end else if (!dma_mode && powered && !cv.busy && !conv_start_reg
                       && (trig_any || (cv.done
                           && chan_reg[adc_dma_pkg::CC_CONT]))) begin
            conv_start_reg <= 1'b1;
            ch_reg         <= chan_reg[3:0];
          end
        end
        D_RUN: begin
          if (go) begin
            if (stop_seen) begin
              dma_state <= D_LAST;
              do_read   <= 1'b0;
              mem_state <= pend_valid ? M_WR_HI : M_IDLE;
            end else begin
              if (next_valid) begin
                conv_start_reg <= 1'b1;
                ch_reg         <= next_id;
                cur_id         <= next_id;
                cur_slot       <= next_slot;
                next_valid     <= 1'b0;
              end
              do_read   <= 1'b1;
              mem_state <= pend_valid ? M_WR_HI : M_RD;
            end
          end
        end
        D_LAST: begin
          if (mem_state == M_IDLE) begin
            dma_state  <= D_IDLE;
            finish_reg <= 1'b1;
          end
        end
        default: dma_state <= D_IDLE;
      endcase

      // Memory steps, one per conversion clock; four fit in a conversion
      if (cv.tick) begin
        case (mem_state)
          M_WR_HI: mem_state <= M_WR_LO;
          M_WR_LO: begin
            pend_valid <= 1'b0;
            mem_state  <= do_read ? M_RD : M_IDLE;
          end
          M_RD:    mem_state <= M_RD_WAIT;
          M_RD_WAIT: begin
            next_id    <= rd_s2[7:4];
            next_slot  <= ptr_reg;
            ptr_reg    <= ptr_reg + adc_dma_pkg::SLOT_STEP;
            mem_state  <= M_IDLE;
            if (rd_s2[7:4] == adc_dma_pkg::STOP_ID) begin
              stop_seen <= 1'b1;
            end else begin
              next_valid <= 1'b1;
            end
          end
          M_IDLE:  ;
          default: mem_state <= M_IDLE;
        endcase
      end

      // Result of the finished conversion waits for the next write slot
      if (cv.done && dma_state != D_IDLE) begin
        pend_res   <= adc_result;
        pend_id    <= cur_id;
        pend_slot  <= cur_slot;
        pend_valid <= 1'b1;
      end

      if (!dma_mode && dma_state != D_IDLE) begin
        dma_state <= D_IDLE;
        mem_state <= M_IDLE;
      end
    end
  end

  // External memory pins; the core is cut off while DMA is enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_addr      <= 24'h000000;
      mem_wdata     <= 8'h00;
      mem_data_oe_n <= 1'b1;
      mem_we_n      <= 1'b1;
      mem_oe_n      <= 1'b1;
      core_rdata    <= 8'h00;
    end else if (dma_mode) begin
      core_rdata    <= adc_dma_pkg::GATED_RD;
      mem_data_oe_n <= !(mem_state == M_WR_HI || mem_state == M_WR_LO);
      mem_we_n      <= !(mem_state == M_WR_HI || mem_state == M_WR_LO);
      mem_oe_n      <= !(mem_state == M_RD || mem_state == M_RD_WAIT);
      case (mem_state)
        M_WR_HI: begin
          mem_addr  <= pend_slot;
          mem_wdata <= {pend_id, pend_res[11:8]};
        end
        M_WR_LO: begin
          mem_addr  <= pend_slot + 24'h000001;
          mem_wdata <= pend_res[7:0];
        end
        default: mem_addr <= ptr_reg;
      endcase
    end else begin
      core_rdata    <= rd_s2;
      mem_addr      <= core_addr;
      mem_wdata     <= core_wdata;
      mem_data_oe_n <= !core_we;
      mem_we_n      <= !core_we;
      mem_oe_n      <= !core_re;
    end
  end

  assign cv.div_sel = timing_reg[adc_dma_pkg::TC_DIV +: 2];
  assign cv.acq_sel = timing_reg[adc_dma_pkg::TC_ACQ +: 2];
  assign cv.start   = conv_start_reg || (cv.done && !dma_mode
    && dma_state == D_IDLE && powered && chan_reg[adc_dma_pkg::CC_CONT]);

  assign adc_channel          = ch_reg;
  assign adc_sampling         = cv.sampling;
  assign adc_power            = powered;
  assign conversion_done_flag = done_reg;
  assign reference_external   = timing_reg[adc_dma_pkg::TC_EXT_REF];
  assign reference_internal_on = powered
    && !timing_reg[adc_dma_pkg::TC_EXT_REF];
endmodule
`default_nettype wire

// file: verification/adc_dma_capture_props.sv
`timescale 1ns/1ps
`default_nettype none
module adc_dma_capture_props (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  // Converter and memory
  input wire logic [3:0]  adc_channel,
  input wire logic        adc_sampling,
  input wire logic        adc_power,
  input wire logic        reference_external,
  input wire logic        reference_internal_on,
  input wire logic        conversion_done_flag,
  input wire logic        mem_data_oe_n,
  input wire logic        mem_we_n,
  input wire logic        mem_oe_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic clr_done;
  assign clr_done = psel && penable && pwrite && pwdata[0]
                    && paddr == adc_dma_pkg::STATUS_OFS;
  ref_select_a: assert property (reference_internal_on |->
    adc_power && !reference_external) else $error("ref select");
  ref_off_a: assert property (!$past(presetn) |->
    !reference_internal_on) else $error("ref on after reset");
  wr_drive_a: assert property (!mem_we_n |->
    !mem_data_oe_n && mem_oe_n) else $error("write strobe");
  rd_release_a: assert property (!mem_oe_n |->
    mem_data_oe_n && mem_we_n) else $error("read strobe");
  rd_step_a: assert property ($fell(mem_oe_n) |=>
    !mem_oe_n) else $error("read step short");
  acq_len_a: assert property ($rose(adc_sampling) |->
    adc_sampling[*2]) else $error("acquire short");
  chan_hold_a: assert property (adc_sampling && $past(adc_sampling)
    |-> $stable(adc_channel)) else $error("channel moved");
  done_hold_a: assert property (conversion_done_flag && !clr_done
    |=> conversion_done_flag) else $error("done lost");
  done_end_a: assert property ($rose(conversion_done_flag) |->
    !$past(adc_sampling)) else $error("done in acquire");
endmodule
bind adc_dma_capture adc_dma_capture_props i_props (.pclk, .presetn,
  .paddr, .psel, .penable, .pwrite, .pwdata, .adc_channel, .adc_sampling,
  .adc_power, .reference_external, .reference_internal_on,
  .conversion_done_flag, .mem_data_oe_n, .mem_we_n, .mem_oe_n);
`default_nettype wire

// file: verification/sram_model.sv
`timescale 1ns/1ps
`default_nettype none
module sram_model (
  // Clock
  input wire logic        pclk,
  // SRAM pins
  input wire logic [23:0] mem_addr,
  input wire logic [7:0]  mem_wdata,
  output logic     [7:0]  mem_rdata,
  input wire logic        mem_data_oe_n,
  input wire logic        mem_we_n,
  input wire logic        mem_oe_n
);
  // Sparse store holds the prepared channel list
  logic [7:0] m [int];
  initial mem_rdata = 8'h5A;
  always @(posedge pclk) begin
    if (!mem_we_n && !mem_data_oe_n) begin
      m[mem_addr] = mem_wdata;
    end
    // Released bus toggles so a stale byte is never mistaken for data
    if (!mem_oe_n && m.exists(mem_addr)) begin
      mem_rdata <= m[mem_addr];
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule
`default_nettype wire

// file: verification/adc_dma_capture_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module adc_dma_capture_tb_top;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, adc_sampling, adc_power;
  logic        timer2_overflow = 1'b0;
  logic        ext_trigger = 1'b0;
  logic [11:0] adc_result = 12'h0;
  logic [3:0]  adc_channel;
  logic        reference_external, reference_internal_on;
  logic        conversion_done_flag, mem_data_oe_n, mem_we_n, mem_oe_n;
  logic [23:0] core_addr = 24'h0;
  logic [7:0]  core_wdata = 8'h0;
  logic        core_we = 1'b0;
  logic        core_re = 1'b0;
  logic [7:0]  core_rdata, mem_wdata, mem_rdata;
  logic [23:0] mem_addr, p;
  logic        samp_q = 1'b0;
  logic [31:0] r;
  logic [1:0]  aa, tg;
  logic [32:0] exp_q[$];
  logic [32:0] exp_v;
  logic [3:0]  ids[5] = '{4'h3, 4'h7, 4'h1, 4'h1, 4'hF};
  int          dv[4] = '{32, 4, 8, 2};
  int          bad_count = 0;
  int          tests_run = 0;
  int          n, n0;
  integer      seed;

  adc_dma_capture i_adc_dma_capture (.pclk, .presetn, .paddr, .psel,
    .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .timer2_overflow, .ext_trigger, .adc_result, .adc_channel,
    .adc_sampling, .adc_power, .reference_external, .reference_internal_on,
    .conversion_done_flag, .core_addr, .core_wdata, .core_we, .core_re,
    .core_rdata, .mem_addr, .mem_wdata, .mem_rdata, .mem_data_oe_n,
    .mem_we_n, .mem_oe_n);
  sram_model i_sram (.pclk, .mem_addr, .mem_wdata, .mem_rdata,
    .mem_data_oe_n, .mem_we_n, .mem_oe_n);

  always #10 pclk = ~pclk;
  always @(posedge pclk) samp_q <= adc_sampling;
  // Read results are checked in the access cycle, oldest note first
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      // Pop once; the macro evaluates its expected value twice
      exp_v = exp_q.pop_front();
      `CHK({pslverr, prdata}, exp_v)
    end
  end

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic e,
                    input logic [31:0] d);
    exp_q.push_back({e, d});
    apb(1'b0, a, 32'h0);
  endtask
  // Cycles up to the next acquisition start
  task automatic rise(output int c);
    c = 0;
    do begin
      @(posedge pclk);
      c++;
    end while (!(adc_sampling && !samp_q) && c < 5000);
  endtask
  task automatic summarize();
    if (bad_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #600000;
    bad_count++;
    summarize();
  end

  initial begin
    seed = 32'h113C54FA;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK(reference_internal_on, 1'b0)
    rd(adc_dma_pkg::TIMING_OFS, 1'b0, 32'h0);
    rd(8'h1C, 1'b1, 32'h0);
    wr(adc_dma_pkg::TIMING_OFS, 32'h0C0);
    `CHK({adc_power, reference_external, reference_internal_on}, 3'b110)
    wr(adc_dma_pkg::TIMING_OFS, 32'h080);
    `CHK({adc_power, reference_external, reference_internal_on}, 3'b101)
    // Free-running period covers every divide code
    for (int d = 0; d < 4; d++) begin
      r = $random(seed);
      aa = (d == 0) ? 2'b11 : r[1:0];
      adc_result <= r[15:4];
      wr(adc_dma_pkg::TIMING_OFS, {24'h0, 2'b10, 2'(d), aa, 2'b00});
      wr(adc_dma_pkg::CHANNEL_OFS, 32'h30 | d);
      rise(n0);
      rise(n);
      `CHK(n, (17 + aa) * dv[d])
      `CHK(adc_channel, 4'(d))
      wr(adc_dma_pkg::CHANNEL_OFS, 32'h0);
      repeat (700) @(posedge pclk);
      rd(adc_dma_pkg::RESULT_OFS, 1'b0, {16'h0, 4'(d), r[15:4]});
    end
    for (int m = 0; m < 3; m++) begin
      p = {8'h12 + 8'(m), 16'h3440};
      r = $random(seed);
      adc_result <= r[11:0];
      tg = (m == 1) ? 2'b10 : (m == 2) ? 2'b01 : 2'b00;
      wr(adc_dma_pkg::TIMING_OFS, 32'h0);
      wr(adc_dma_pkg::STATUS_OFS, 32'h1);
      wr(adc_dma_pkg::PTR_LOW_OFS, {24'h0, p[7:0]});
      wr(adc_dma_pkg::PTR_HIGH_OFS, {24'h0, p[15:8]});
      wr(adc_dma_pkg::PTR_PAGE_OFS, {24'h0, p[23:16]});
      for (int k = 0; k < 5; k++) i_sram.m[p + 2 * k] = {ids[k], 4'h0};
      wr(adc_dma_pkg::CHANNEL_OFS, 32'h40);
      // Divide by 8 keeps the conversion clock inside its legal range
      wr(adc_dma_pkg::TIMING_OFS, {24'h0, 6'h28, tg});
      core_we <= 1'b1;
      core_re <= 1'b1;
      core_addr <= p + 24'h20;
      if (m == 0) wr(adc_dma_pkg::CHANNEL_OFS, 32'h50);
      n = 0;
      while (!conversion_done_flag && n < 4000) begin
        @(posedge pclk);
        n++;
        timer2_overflow <= (m == 1) && (n % 250 == 0);
        ext_trigger <= (m == 2) && (n % 250 < 20);
        if (n == 60) `CHK(core_rdata, 8'hFF)
      end
      timer2_overflow <= 1'b0;
      ext_trigger <= 1'b0;
      core_we <= 1'b0;
      core_re <= 1'b0;
      `CHK(conversion_done_flag, 1'b1)
      if (m == 0) `CHK(n <= 1200, 1'b1)
      repeat (40) @(posedge pclk);
      for (int k = 0; k < 4; k++) begin
        `CHK(i_sram.m[p + 2 * k], {ids[k], r[11:8]})
        `CHK(i_sram.m[p + 2 * k + 1], r[7:0])
      end
      `CHK(i_sram.m[p + 8], 8'hF0)
      `CHK(i_sram.m.exists(p + 9), 0)
      `CHK(i_sram.m.exists(p + 24'h20), 0)
      rd(adc_dma_pkg::STATUS_OFS, 1'b0, 32'h1);
      wr(adc_dma_pkg::CHANNEL_OFS, 32'h0);
    end
    summarize();
  end
endmodule
`default_nettype wire
